/* File: core/fcs_map.vh */
// Purpose: Offsets, fields, reset values and timing of the fault collector
// Assumes: 32-bit AXI4-Lite register bus, core_clk at 10 MHz
// Notes:   Definitions only
//
// Functional notes
// - Interrupt-enable register bit 28 is writable and reads back.
// - Supervision starts only on a rising edge of a fault input.
// - Fault asserted before being enabled blocks its supervision edge detection.
// - Enabled fault asserting in configuration state blocks its edge detection.
// - Blocked detection stays blocked until a reaction or destructive reset.
// - Reset-only faults are not supervised on second and later occurrences.
// - Fault rising during a functional reset reaction escapes later supervision.
`ifndef FCS_MAP_VH
`define FCS_MAP_VH

`define FCS_NCF          8
`define FCS_AW           8

`define FCS_OFF_CTRL     8'h00
`define FCS_OFF_EN       8'h04
`define FCS_OFF_STAT     8'h08
`define FCS_OFF_FAKE     8'h0C
`define FCS_OFF_IRQEN    8'h10
`define FCS_OFF_REACT    8'h14
`define FCS_OFF_SUP      8'h18
`define FCS_OFF_ISTAT    8'h1C
`define FCS_OFF_IMASK    8'h20

`define FCS_CTRL_CFG     0
`define FCS_IRQEN_RSV    28
`define FCS_REACT_ERROR_OUTPUT_SIGNAL   0
`define FCS_REACT_RST    8
`define FCS_REACT_ALARM  16
`define FCS_SUP_BLK      0
`define FCS_SUP_ESC      8
`define FCS_SUP_ACT      16

`define FCS_IS_SUPERR    0
`define FCS_IS_SUPSTART  1
`define FCS_IS_REACT     2
`define FCS_INT_W        3

`define FCS_RST_CTRL     1'h0
`define FCS_RESP_OKAY    2'h0
`define FCS_RESP_SLVERR  2'h2

`define FCS_CLK_NS       100
`define FCS_SUP_WIN_NS   1000
`define FCS_SUP_CYC      (`FCS_SUP_WIN_NS / `FCS_CLK_NS)
`define FCS_RST_HOLD_NS  2000
`define FCS_RST_CYC      ((`FCS_RST_HOLD_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)

`endif

/* File: core/fcs_sup_chan.v */
// Purpose: One supervision channel: input filter, edge arming, window check
// Assumes: fault_raw is asynchronous to core_clk
// Notes:   Destructive reset is resetn
`timescale 1ns/1ps
`default_nettype none
`include "fcs_map.vh"

module fcs_sup_chan (
  input  wire       core_clk,
  input  wire       resetn,
  input  wire       fault_raw,
  input  wire       enabled,
  input  wire       config_state,
  input  wire       reinit,
  input  wire       reset_only,
  input  wire       reset_active,
  input  wire       react_obs,
  output reg        level,
  output reg        blocked,
  output reg        escaped,
  output reg        sup_active,
  output reg        sup_start,
  output reg        sup_error
);

  localparam integer SUP_CYC_I = `FCS_SUP_CYC;
  localparam [3:0]   SUP_CYC   = SUP_CYC_I[3:0];

  reg       s1;
  reg       s2;
  reg       s3;
  reg       level_d;
  reg [3:0] cnt;

  wire rise    = level & ~level_d;
  wire monitor = rise & enabled & ~config_state & ~blocked & ~escaped;

  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s1         <= 1'h0;
      s2         <= 1'h0;
      s3         <= 1'h0;
      level      <= 1'h0;
      level_d    <= 1'h0;
      blocked    <= 1'h0;
      escaped    <= 1'h0;
      sup_active <= 1'h0;
      sup_start  <= 1'h0;
      sup_error  <= 1'h0;
      cnt        <= 4'h0;
    end
    else
    begin
      s1      <= fault_raw;
      s2      <= s1;
      s3      <= s2;
      if (s2 == s3)
        level <= s3;
      level_d <= level;
      // Blocking wins over re-initialisation in the same cycle
      if ((level & ~enabled) | (rise & enabled & config_state))
        blocked <= 1'h1;
      else if (reinit)
        blocked <= 1'h0;
      if ((monitor & reset_only) | (rise & enabled & reset_active))
        escaped <= 1'h1;
      sup_start <= monitor;
      sup_error <= 1'h0;
      if (monitor)
      begin
        sup_active <= 1'h1;
        cnt        <= SUP_CYC;
      end
      else if (sup_active)
      begin
        if (react_obs)
          sup_active <= 1'h0;
        else if (cnt == 4'h1)
        begin
          sup_error  <= 1'h1;
          sup_active <= 1'h0;
        end
        else
          cnt <= cnt - 4'h1;
      end
    end
  end

endmodule
`default_nettype wire

/* File: core/fcs_fault_collector.v */
// Purpose: Fault collector with output supervision and AXI4-Lite registers
// Assumes: Fault inputs asynchronous, single clock core_clk
// Notes:   Reactions: interrupt, error output, functional reset request
`timescale 1ns/1ps
`default_nettype none
`include "fcs_map.vh"

module fcs_fault_collector (
  input  wire                 core_clk,
  input  wire                 resetn,
  input  wire [`FCS_AW-1:0]   awaddr,
  input  wire                 awvalid,
  output reg                  awready,
  input  wire [31:0]          wdata,
  input  wire [3:0]           wstrb,
  input  wire                 wvalid,
  output reg                  wready,
  output reg  [1:0]           bresp,
  output reg                  bvalid,
  input  wire                 bready,
  input  wire [`FCS_AW-1:0]   araddr,
  input  wire                 arvalid,
  output reg                  arready,
  output reg  [31:0]          rdata,
  output reg  [1:0]           rresp,
  output reg                  rvalid,
  input  wire                 rready,
  input  wire [`FCS_NCF-1:0]  fault_in,
  output reg                  fault_irq_out,
  output reg                  error_output_signal,
  output reg                  func_reset_req,
  output reg                  irq
);

  localparam N = `FCS_NCF;
  localparam integer RST_CYC_I = `FCS_RST_CYC;
  localparam [4:0]   RST_CYC   = RST_CYC_I[4:0];

  // Software state
  reg                  cfg;
  reg [N-1:0]          fault_en;
  reg [N-1:0]          noncritical_fault_status;
  reg [N-1:0]          noncritical_fake_fault;
  reg [N-1:0]          irq_en;
  reg                  irq_rsv;
  reg [N-1:0]          error_output_signal_en;
  reg [N-1:0]          rst_en;
  reg [N-1:0]          alarm_timeout_enable;
  reg [`FCS_INT_W-1:0] int_status;
  reg [`FCS_INT_W-1:0] int_mask;

  // Bus capture
  reg                  aw_got;
  reg                  w_got;
  reg [`FCS_AW-1:0]    awaddr_q;
  reg [31:0]           wdata_q;
  reg [3:0]            wstrb_q;

  // Reaction state
  reg [N-1:0]          act_q;
  reg [4:0]            rst_cnt;

  wire [N-1:0]         lvl;
  wire [N-1:0]         blocked;
  wire [N-1:0]         escaped;
  wire [N-1:0]         sup_act;
  wire [N-1:0]         sup_start;
  wire [N-1:0]         sup_error;

  wire        wr_go = aw_got & w_got & ~bvalid;
  wire [31:0] bmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
                       {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  wire [31:0] wclr  = wdata_q & bmask;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [31:0] m;
    begin
      merge = (old & ~m) | (nw & m);
    end
  endfunction

  // Byte-lane merged write values, cut back to the field widths below
  wire [31:0] en_word    = merge({{(32-N){1'h0}}, fault_en},
                                 wdata_q, bmask);
  wire [31:0] irqen_word = merge({{(32-N){1'h0}}, irq_en},
                                 wdata_q, bmask);
  wire [31:0] error_output_signal_word  = merge({{(32-N){1'h0}}, error_output_signal_en},
                                 wdata_q, bmask);
  wire [31:0] rst_word   = merge({{(32-N){1'h0}}, rst_en},
                                 wdata_q >> `FCS_REACT_RST,
                                 bmask >> `FCS_REACT_RST);
  wire [31:0] alarm_word = merge({{(32-N){1'h0}}, alarm_timeout_enable},
                                 wdata_q >> `FCS_REACT_ALARM,
                                 bmask >> `FCS_REACT_ALARM);

  wire hit_ctrl  = wr_go & (awaddr_q == `FCS_OFF_CTRL);
  wire hit_en    = wr_go & (awaddr_q == `FCS_OFF_EN);
  wire hit_stat  = wr_go & (awaddr_q == `FCS_OFF_STAT);
  wire hit_fake  = wr_go & (awaddr_q == `FCS_OFF_FAKE);
  wire hit_irqen = wr_go & (awaddr_q == `FCS_OFF_IRQEN);
  wire hit_react = wr_go & (awaddr_q == `FCS_OFF_REACT);
  wire hit_istat = wr_go & (awaddr_q == `FCS_OFF_ISTAT);
  wire hit_imask = wr_go & (awaddr_q == `FCS_OFF_IMASK);
  wire wr_map    = hit_ctrl | hit_en | hit_stat | hit_fake | hit_irqen |
                   hit_react | hit_istat | hit_imask |
                   (awaddr_q == `FCS_OFF_SUP);

  // Reaction generation
  wire [N-1:0] act        = noncritical_fault_status & fault_en & {N{~cfg}};
  wire [N-1:0] fire       = act & ~act_q;
  wire [N-1:0] nonrst     = irq_en | error_output_signal_en | alarm_timeout_enable;
  wire [N-1:0] reset_only = rst_en & ~nonrst;
  wire         reinit     = |fire;
  wire         rst_fire   = |(fire & rst_en);
  wire         reset_active = (rst_cnt != 5'h0);
  wire         react_obs  = fault_irq_out | error_output_signal | reset_active;

  wire [`FCS_INT_W-1:0] int_set;
  assign int_set[`FCS_IS_SUPERR]   = |sup_error;
  assign int_set[`FCS_IS_SUPSTART] = |sup_start;
  assign int_set[`FCS_IS_REACT]    = reinit;

  // Reaction levels for the registered outputs
  wire next_fault_irq = |(act & irq_en);
  wire next_error_output_signal      = |(act & (error_output_signal_en | alarm_timeout_enable));
  wire next_irq       = |(int_status & int_mask);

  // Sticky flags: a set in the same cycle as a write-one clear wins
  reg [N-1:0]          next_status;
  reg [`FCS_INT_W-1:0] next_int_status;
  reg [4:0]            next_rst_cnt;

  always @*
  begin
    next_status     = noncritical_fault_status;
    next_int_status = int_status;
    if (hit_stat)
      next_status = next_status & ~wclr[N-1:0];
    if (hit_istat)
      next_int_status = next_int_status & ~wclr[`FCS_INT_W-1:0];
    next_status     = next_status | lvl | noncritical_fake_fault;
    next_int_status = next_int_status | int_set;

    // Reset reaction window reloads on every new reset request
    next_rst_cnt    = rst_cnt;
    if (rst_fire)
      next_rst_cnt = RST_CYC;
    else if (reset_active)
      next_rst_cnt = rst_cnt - 5'h1;
  end

  genvar g;
  generate
    for (g = 0; g < N; g = g + 1)
    begin : chan
      fcs_sup_chan u_chan (
        .core_clk     (core_clk),
        .resetn       (resetn),
        .fault_raw    (fault_in[g]),
        .enabled      (fault_en[g]),
        .config_state (cfg),
        .reinit       (reinit),
        .reset_only   (reset_only[g]),
        .reset_active (reset_active),
        .react_obs    (react_obs),
        .level        (lvl[g]),
        .blocked      (blocked[g]),
        .escaped      (escaped[g]),
        .sup_active   (sup_act[g]),
        .sup_start    (sup_start[g]),
        .sup_error    (sup_error[g])
      );
    end
  endgenerate

  // Read decode
  reg [31:0] rd_data;
  reg        rd_err;

  always @*
  begin
    rd_data = 32'h0;
    rd_err  = 1'h0;
    case (araddr)
      `FCS_OFF_CTRL:
        rd_data[`FCS_CTRL_CFG] = cfg;
      `FCS_OFF_EN:
        rd_data[N-1:0] = fault_en;
      `FCS_OFF_STAT:
        rd_data[N-1:0] = noncritical_fault_status;
      `FCS_OFF_FAKE:
        rd_data = 32'h0;
      `FCS_OFF_IRQEN:
      begin
        rd_data[N-1:0]            = irq_en;
        rd_data[`FCS_IRQEN_RSV]   = irq_rsv;
      end
      `FCS_OFF_REACT:
      begin
        rd_data[`FCS_REACT_ERROR_OUTPUT_SIGNAL+N-1:`FCS_REACT_ERROR_OUTPUT_SIGNAL]   = error_output_signal_en;
        rd_data[`FCS_REACT_RST+N-1:`FCS_REACT_RST]     = rst_en;
        rd_data[`FCS_REACT_ALARM+N-1:`FCS_REACT_ALARM] = alarm_timeout_enable;
      end
      `FCS_OFF_SUP:
      begin
        rd_data[`FCS_SUP_BLK+N-1:`FCS_SUP_BLK] = blocked;
        rd_data[`FCS_SUP_ESC+N-1:`FCS_SUP_ESC] = escaped;
        rd_data[`FCS_SUP_ACT+N-1:`FCS_SUP_ACT] = sup_act;
      end
      `FCS_OFF_ISTAT:
        rd_data[`FCS_INT_W-1:0] = int_status;
      `FCS_OFF_IMASK:
        rd_data[`FCS_INT_W-1:0] = int_mask;
      default:
        rd_err = 1'h1;
    endcase
  end

  // AXI4-Lite handshakes
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      awready  <= 1'h1;
      wready   <= 1'h1;
      bvalid   <= 1'h0;
      bresp    <= `FCS_RESP_OKAY;
      arready  <= 1'h1;
      rvalid   <= 1'h0;
      rresp    <= `FCS_RESP_OKAY;
      rdata    <= 32'h0;
      aw_got   <= 1'h0;
      w_got    <= 1'h0;
      awaddr_q <= {`FCS_AW{1'h0}};
      wdata_q  <= 32'h0;
      wstrb_q  <= 4'h0;
    end
    else
    begin
      if (awvalid & awready)
      begin
        awready  <= 1'h0;
        aw_got   <= 1'h1;
        awaddr_q <= awaddr;
      end
      if (wvalid & wready)
      begin
        wready  <= 1'h0;
        w_got   <= 1'h1;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
      if (wr_go)
      begin
        bvalid <= 1'h1;
        bresp  <= wr_map ? `FCS_RESP_OKAY : `FCS_RESP_SLVERR;
        aw_got <= 1'h0;
        w_got  <= 1'h0;
      end
      if (bvalid & bready)
      begin
        bvalid  <= 1'h0;
        awready <= 1'h1;
        wready  <= 1'h1;
      end
      if (arvalid & arready)
      begin
        arready <= 1'h0;
        rvalid  <= 1'h1;
        rdata   <= rd_data;
        rresp   <= rd_err ? `FCS_RESP_SLVERR : `FCS_RESP_OKAY;
      end
      else if (rvalid & rready)
      begin
        rvalid  <= 1'h0;
        arready <= 1'h1;
      end
    end
  end

  // Register file, status flags and reactions
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cfg                      <= `FCS_RST_CTRL;
      fault_en                 <= {N{1'h0}};
      noncritical_fault_status <= {N{1'h0}};
      noncritical_fake_fault   <= {N{1'h0}};
      irq_en                   <= {N{1'h0}};
      irq_rsv                  <= 1'h0;
      error_output_signal_en                  <= {N{1'h0}};
      rst_en                   <= {N{1'h0}};
      alarm_timeout_enable     <= {N{1'h0}};
      int_status               <= {`FCS_INT_W{1'h0}};
      int_mask                 <= {`FCS_INT_W{1'h0}};
      act_q                    <= {N{1'h0}};
      rst_cnt                  <= 5'h0;
      fault_irq_out            <= 1'h0;
      error_output_signal      <= 1'h0;
      func_reset_req           <= 1'h0;
      irq                      <= 1'h0;
    end
    else
    begin
      if (hit_ctrl & wstrb_q[0])
        cfg <= wdata_q[`FCS_CTRL_CFG];
      if (hit_en)
        fault_en <= en_word[N-1:0];
      if (hit_irqen)
      begin
        irq_en  <= irqen_word[N-1:0];
        if (wstrb_q[3])
          irq_rsv <= wdata_q[`FCS_IRQEN_RSV];
      end
      if (hit_react)
      begin
        error_output_signal_en              <= error_output_signal_word[N-1:0];
        rst_en               <= rst_word[N-1:0];
        alarm_timeout_enable <= alarm_word[N-1:0];
      end
      if (hit_imask)
        int_mask <= wdata_q[`FCS_INT_W-1:0] & bmask[`FCS_INT_W-1:0];
      // Fake faults last one cycle and act like a fault event
      noncritical_fake_fault <= hit_fake ? wclr[N-1:0] : {N{1'h0}};
      // Pending status is set whether or not the fault is enabled
      noncritical_fault_status <= next_status;
      int_status               <= next_int_status;
      act_q               <= act;
      fault_irq_out       <= next_fault_irq;
      error_output_signal <= next_error_output_signal;
      func_reset_req      <= rst_fire;
      rst_cnt             <= next_rst_cnt;
      irq                 <= next_irq;
    end
  end

endmodule
`default_nettype wire

/* File: dv/fcs_fault_collector_monitor.sv */
// Purpose: Port timing checks on the fault collector
// Assumes: One clock, resetn asynchronous active low
// Notes:   Bound from the bench top
`timescale 1ns/1ps
`default_nettype none
`include "fcs_map.vh"
module fcs_fault_collector_monitor (
  input wire logic               core_clk,
  input wire logic               resetn,
  input wire logic [`FCS_AW-1:0] awaddr,
  input wire logic               awvalid,
  input wire logic               awready,
  input wire logic [31:0]        wdata,
  input wire logic [3:0]         wstrb,
  input wire logic               wvalid,
  input wire logic               wready,
  input wire logic [1:0]         bresp,
  input wire logic               bvalid,
  input wire logic               bready,
  input wire logic [`FCS_AW-1:0] araddr,
  input wire logic               arvalid,
  input wire logic               arready,
  input wire logic [31:0]        rdata,
  input wire logic [1:0]         rresp,
  input wire logic               rvalid,
  input wire logic               rready,
  input wire logic [`FCS_NCF-1:0] fault_in,
  input wire logic               fault_irq_out,
  input wire logic               error_output_signal,
  input wire logic               func_reset_req,
  input wire logic               irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  property p_wr_answer;
    awvalid && awready && wvalid && wready |-> ##2 bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer)
    else $error("write answer late");
  property p_b_hold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write answer dropped");
  property p_rd_answer;
    arvalid && arready |=> rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read answer late");
  property p_r_hold;
    rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read answer dropped");
  property p_aw_busy;
    bvalid |-> !awready && !wready;
  endproperty
  a_aw_busy: assert property (p_aw_busy)
    else $error("write taken while busy");
  property p_ar_busy;
    rvalid |-> !arready;
  endproperty
  a_ar_busy: assert property (p_ar_busy)
    else $error("read taken while busy");
  property p_rst_pulse;
    func_reset_req |=> !func_reset_req;
  endproperty
  a_rst_pulse: assert property (p_rst_pulse)
    else $error("reset request longer than a cycle");
  property p_rst_vals;
    $rose(resetn) |-> awready && arready && !bvalid && !rvalid && !irq
      && !fault_irq_out && !func_reset_req && !error_output_signal;
  endproperty
  a_rst_vals: assert property (p_rst_vals)
    else $error("outputs not idle after reset");
endmodule
`default_nettype wire

/* File: dv/fcs_fault_src.sv */
// Purpose: Fault sources and reset reaction sink facing the collector
// Assumes: Fault lines are levels held until dropped
// Notes:   Lines change just after a clock edge
`timescale 1ns/1ps
`default_nettype none
module fcs_fault_src (
  input  wire logic       core_clk,
  input  wire logic [7:0] raise,
  input  wire logic [7:0] drop,
  input  wire logic       func_reset_req,
  output var  logic [7:0] fault_in,
  output var  logic [7:0] resets
);
  initial fault_in = 8'h00;
  initial resets = 8'h00;
  always @(posedge core_clk)
  begin
    fault_in <= (fault_in | raise) & ~drop;
    if (func_reset_req)
      resets <= resets + 8'h01;
  end
endmodule
`default_nettype wire

/* File: dv/fcs_fault_collector_tb.sv */
// Purpose: Self-checking bench for the fault collector
// Assumes: AXI4-Lite master tasks, fault sources in fcs_fault_src
// Notes:   Seeded random data and ready delays
`timescale 1ns/1ps
`default_nettype none
`include "fcs_map.vh"
module fcs_fault_collector_tb;
  logic        core_clk, resetn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr, raise, drop, fault_in, resets;
  logic [31:0] wdata, d, v;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic        fault_irq_out, error_output_signal, func_reset_req;
  int          miscompares, checks, i;
  fcs_fault_collector dut (.core_clk(core_clk), .resetn(resetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .fault_in(fault_in), .fault_irq_out(fault_irq_out),
    .error_output_signal(error_output_signal),
    .func_reset_req(func_reset_req), .irq(irq));
  fcs_fault_src src (.core_clk(core_clk), .raise(raise), .drop(drop),
    .func_reset_req(func_reset_req), .fault_in(fault_in), .resets(resets));
  function automatic logic [31:0] irqen_exp(input logic [31:0] w);
    return w & ((32'h1 << `FCS_IRQEN_RSV) | 32'hFF);
  endfunction
  task automatic final_report;
    if (miscompares == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      miscompares++;
    end
  endtask
  task automatic tmo;
    miscompares++;
    final_report();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] w,
                    input logic [1:0] er = `FCS_RESP_OKAY);
    int n;
    int s;
    s = $urandom_range(3);
    @(posedge core_clk);
    awaddr <= a;
    wdata <= w;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (n = 0; n < 100; n++)
    begin
      @(posedge core_clk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid && bready)
        break;
      if (n == s)
        bready <= 1'b1;
    end
    bready <= 1'b0;
    if (n == 100)
      tmo();
    chk({30'h0, bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q,
                    input logic [1:0] er = `FCS_RESP_OKAY);
    int n;
    int s;
    s = $urandom_range(3);
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    for (n = 0; n < 100; n++)
    begin
      @(posedge core_clk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid && rready)
        break;
      if (n == s)
        rready <= 1'b1;
    end
    rready <= 1'b0;
    q = rdata;
    if (n == 100)
      tmo();
    chk({30'h0, rresp}, {30'h0, er});
  endtask
  task automatic poll(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e);
    logic [31:0] q;
    int          n;
    q = 'x;
    for (n = 0; n < 40 && (q & m) !== e; n++)
      rd(a, q);
    chk(q & m, e);
  endtask
  task automatic fl(input logic [7:0] m);
    raise <= m;
    @(posedge core_clk);
    raise <= 8'h00;
  endtask
  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  initial
  begin
    resetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata} = 48'h0;
    wstrb = 4'hF;
    raise = 8'h02;
    drop = 8'h00;
    miscompares = 0;
    checks = 0;
    v = $urandom(32'h7BF4);
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    raise <= 8'h00;
    poll(`FCS_OFF_STAT, 32'h02, 32'h02);
    poll(`FCS_OFF_SUP, 32'hFF, 32'h02);
    for (i = 0; i < 6; i++)
    begin
      v = $urandom();
      v[`FCS_IRQEN_RSV] = (i == 0) ? 1'b1 : v[`FCS_IRQEN_RSV];
      wr(`FCS_OFF_IRQEN, v);
      rd(`FCS_OFF_IRQEN, d);
      chk(d, irqen_exp(v));
    end
    wr(`FCS_OFF_IRQEN, 32'h06);
    rd(`FCS_OFF_IRQEN, d);
    chk(d, 32'h06);
    rd(8'h40, d, `FCS_RESP_SLVERR);
    chk(d, 32'h0);
    wr(`FCS_OFF_SUP, 32'hFFFF_FFFF);
    wr(`FCS_OFF_REACT, 32'h0004_1000);
    wr(`FCS_OFF_IMASK, 32'h02);
    wr(`FCS_OFF_EN, 32'h06);
    poll(`FCS_OFF_SUP, 32'hFF, 32'h00);
    rd(`FCS_OFF_ISTAT, d);
    chk(d & 32'h2, 32'h0);
    chk({31'h0, fault_irq_out}, 32'h1);
    fl(8'h04);
    poll(`FCS_OFF_ISTAT, 32'h2, 32'h2);
    repeat (12) @(posedge core_clk);
    chk({31'h0, error_output_signal}, 32'h1);
    rd(`FCS_OFF_ISTAT, d);
    chk(d & 32'h1, 32'h0);
    chk({31'h0, irq}, 32'h1);
    wr(`FCS_OFF_IMASK, 32'h0);
    repeat (2) @(posedge core_clk);
    chk({31'h0, irq}, 32'h0);
    wr(`FCS_OFF_ISTAT, 32'h7);
    rd(`FCS_OFF_ISTAT, d);
    chk(d, 32'h0);
    wr(`FCS_OFF_CTRL, 32'h1);
    wr(`FCS_OFF_IRQEN, 32'h0E);
    wr(`FCS_OFF_EN, 32'h0E);
    fl(8'h08);
    poll(`FCS_OFF_SUP, 32'hFF, 32'h08);
    chk({31'h0, fault_irq_out}, 32'h0);
    wr(`FCS_OFF_CTRL, 32'h0);
    rd(`FCS_OFF_STAT, d);
    chk(d & 32'h08, 32'h08);
    wr(`FCS_OFF_EN, 32'h4E);
    wr(`FCS_OFF_ISTAT, 32'h7);
    rd(`FCS_OFF_ISTAT, d);
    chk(d & 32'h4, 32'h0);
    wr(`FCS_OFF_FAKE, 32'h40);
    poll(`FCS_OFF_STAT, 32'h40, 32'h40);
    poll(`FCS_OFF_ISTAT, 32'h4, 32'h4);
    rd(`FCS_OFF_FAKE, d);
    chk(d, 32'h0);
    poll(`FCS_OFF_SUP, 32'hFF, 32'h00);
    wr(`FCS_OFF_IRQEN, 32'h2E);
    wr(`FCS_OFF_EN, 32'h3E);
    fl(8'h10);
    for (i = 0; i < 40 && func_reset_req !== 1'b1; i++)
      @(posedge core_clk);
    if (i == 40)
      tmo();
    fl(8'h20);
    poll(`FCS_OFF_SUP, 32'hFF00, 32'h3000);
    chk({24'h0, resets}, 32'h1);
    resetn <= 1'b0;
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    poll(`FCS_OFF_SUP, 32'hFFFF, 32'h003E);
    final_report();
  end
endmodule
bind fcs_fault_collector fcs_fault_collector_monitor u_mon (
  .core_clk(core_clk), .resetn(resetn), .awaddr(awaddr),
  .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
  .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
  .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
  .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
  .fault_in(fault_in), .fault_irq_out(fault_irq_out),
  .error_output_signal(error_output_signal),
  .func_reset_req(func_reset_req), .irq(irq));
`default_nettype wire
